/* logic/scu_pkg.sv */
package scu_pkg;

	// fixed upper part of the seven-bit slave address
	localparam logic [3:0] ADDR_PREFIX = 4'h9;

	// number of configuration registers
	localparam int NREG = 4;

	// register pointers
	localparam logic [7:0] PTR_HS_MODES  = 8'h00;
	localparam logic [7:0] PTR_AUX_MODES = 8'h01;
	localparam logic [7:0] PTR_RX_SET    = 8'h10;
	localparam logic [7:0] PTR_TX_SET    = 8'h21;

	// register indices
	localparam logic [1:0] IDX_HS  = 2'h0;
	localparam logic [1:0] IDX_AUX = 2'h1;
	localparam logic [1:0] IDX_RX  = 2'h2;
	localparam logic [1:0] IDX_TX  = 2'h3;

	// constant rx default, unmapped read and reset values
	localparam logic [7:0] RX_SET_DEFAULT = 8'h01;
	localparam logic [7:0] UNMAPPED_READ  = 8'h00;
	localparam logic [7:0] CFG_RESET      = 8'h00;

	// clock period and per-register update windows
	localparam int CLK_PERIOD_PS = 5000;
	localparam int UPD_HS_NS     = 1000;
	localparam int UPD_AUX_NS    = 1000;
	localparam int UPD_RX_NS     = 500;
	localparam int UPD_TX_NS     = 500;
	localparam int UPD_CYC [NREG] = '{
		(UPD_HS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS,
		(UPD_AUX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS,
		(UPD_RX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS,
		(UPD_TX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS
	};

	// serial engine states, gray along the write path
	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_ADDR  = 4'h1,
		S_ACK_A = 4'h3,
		S_PTR   = 4'h2,
		S_ACK_P = 4'h6,
		S_WDATA = 4'h7,
		S_ACK_W = 4'h5,
		S_WAIT  = 4'h4,
		S_RDATA = 4'hc,
		S_RACK  = 4'hd
	} scu_state_e;

	// pointer decode: {hit, index}
	function automatic logic [2:0] ptr_decode(input logic [7:0] p);
		logic [2:0] r;
		r = 3'h0;
		case (p)
			PTR_HS_MODES:  r = {1'b1, IDX_HS};
			PTR_AUX_MODES: r = {1'b1, IDX_AUX};
			PTR_RX_SET:    r = {1'b1, IDX_RX};
			PTR_TX_SET:    r = {1'b1, IDX_TX};
			default:       r = 3'h0;
		endcase
		return r;
	endfunction

endpackage

/* logic/scu_serial_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - low reset restores the whole register set
// - hs, aux and tx defaults follow the parallel configuration inputs, rx default is constant
// - parallel control until first matching address
// - first matching address hands over to serial
// - parallel ignored until next reset
// - address is prefix 1001 plus straps
// - write direction bit, acknowledged on match
// - pointer byte latched and acknowledged
// - data byte stored at pointer, acknowledged
// - repeated start read reuses stored pointer
// - read address with direction one acknowledged
// - selected register shifted out msb first
// - configuration changes reach hardware after delay
// - serial delay starts at last bit fall
// - parallel delay starts at pin transition
// - each register has its own window
// - writes in window do not restart it
// - window close applies newest value
// - write after window applies immediately
module scu_serial_ctrl (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	input  wire logic       slave_addr_strap_bit2,
	input  wire logic       slave_addr_strap_bit1,
	input  wire logic       slave_addr_strap_bit0,
	input  wire logic       par_out_en,
	input  wire logic [1:0] par_sel,
	input  wire logic [1:0] par_pre,
	input  wire logic       par_oto,
	input  wire logic       par_ocl,
	output logic      [7:0] phys_hs_modes,
	output logic      [7:0] phys_aux_modes,
	output logic      [7:0] phys_rx_set,
	output logic      [7:0] phys_tx_set,
	output logic            serial_mode
);

	localparam int NREG = scu_pkg::NREG;

	// synchronised pins
	logic [11:0] pin_s;
	wire         scl_s  = pin_s[11];
	wire         sda_s  = pin_s[10];
	wire  [2:0]  strap  = pin_s[9:7];
	wire         p_en   = pin_s[6];
	wire  [1:0]  p_sel  = pin_s[5:4];
	wire  [1:0]  p_pre  = pin_s[3:2];
	wire         p_oto  = pin_s[1];
	wire         p_ocl  = pin_s[0];

	// engine state
	scu_pkg::scu_state_e state_reg;	// current engine state
	scu_pkg::scu_state_e state_next;
	logic [3:0]  cnt_reg;		// scl rises in current byte
	logic [3:0]  cnt_next;
	logic [7:0]  shift_reg;		// incoming bits
	logic [7:0]  ptr_reg;		// register pointer
	logic [7:0]  tx_reg;		// outgoing bits
	logic [7:0]  tx_next;
	logic        rw_reg;		// direction of the last address
	logic        drive_reg;		// pulls sda low when set
	logic        drive_next;
	logic        serial_reg;	// serial control has taken over
	logic        scl_prev_reg;	// previous synced scl
	logic        sda_prev_reg;	// previous synced sda

	// register set and its next values
	logic [7:0]  cfg_reg   [NREG];
	logic [7:0]  cfg_next  [NREG];
	logic [7:0]  par_word  [NREG];
	logic [7:0]  phys      [NREG];
	logic [NREG-1:0] kick;

	// all pins through two flops first
	scu_sync #(
		.W (12)
	) u_sync (
		.clk    (ref_clk),
		.resetn (resetn),
		.d      ({scl_in, sda_in, slave_addr_strap_bit2, slave_addr_strap_bit1,
		          slave_addr_strap_bit0, par_out_en, par_sel, par_pre, par_oto,
		          par_ocl}),
		.q      (pin_s)
	);

	// bus edge and condition decode
	wire scl_rise  = scl_s & ~scl_prev_reg;
	wire scl_fall  = ~scl_s & scl_prev_reg;
	wire start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
	wire stop_det  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
	wire byte_done = scl_fall & (cnt_reg == 4'h8);

	wire addr_match = (shift_reg[7:1] == {scu_pkg::ADDR_PREFIX, strap});
	wire ack_addr   = (state_reg == scu_pkg::S_ADDR) & byte_done & addr_match;
	// write strobe at last bit fall
	wire wr_stb     = (state_reg == scu_pkg::S_WDATA) & byte_done;

	// pointer decode shared by read and write
	wire [2:0] ptr_dec = scu_pkg::ptr_decode(ptr_reg);
	wire       ptr_hit = ptr_dec[2];
	wire [1:0] ptr_idx = ptr_dec[1:0];
	wire [7:0] rd_val  = ptr_hit ? cfg_reg[ptr_idx] : scu_pkg::UNMAPPED_READ;

	// parallel pins mapped to register defaults
	assign par_word[scu_pkg::IDX_HS]  = {1'b0, p_en, 4'h0, p_sel};
	assign par_word[scu_pkg::IDX_AUX] = {1'b0, p_en, 4'h0, p_sel};
	assign par_word[scu_pkg::IDX_RX]  = scu_pkg::RX_SET_DEFAULT;
	assign par_word[scu_pkg::IDX_TX]  = {4'h0, p_pre, p_oto, p_ocl};

	// register next values and update windows
	for (genvar i = 0; i < NREG; i++) begin : g_reg
		wire wr_hit = wr_stb & ptr_hit & (ptr_idx == 2'(i));
		// parallel values until serial takeover
		assign cfg_next[i] = !serial_reg ? par_word[i] :
		                     wr_hit ? shift_reg : cfg_reg[i];
		// pin change or serial write kicks
		assign kick[i] = wr_hit | (cfg_next[i] != cfg_reg[i]);

		scu_upd_delay #(
			.WIN (scu_pkg::UPD_CYC[i])
		) u_upd (
			.clk    (ref_clk),
			.resetn (resetn),
			.cfg_in (cfg_next[i]),
			.kick   (kick[i]),
			.phys   (phys[i])
		);

		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn) begin
				cfg_reg[i] <= scu_pkg::CFG_RESET;
			end else begin
				cfg_reg[i] <= cfg_next[i];
			end
		end
	end

	// engine next state, counter and drive
	always_comb begin
		state_next = state_reg;
		cnt_next   = scl_rise ? cnt_reg + 4'h1 : cnt_reg;
		drive_next = drive_reg;
		tx_next    = tx_reg;
		if (stop_det) begin
			// stop frees the bus
			state_next = scu_pkg::S_IDLE;
			drive_next = 1'b0;
		end else if (start_det) begin
			state_next = scu_pkg::S_ADDR;
			cnt_next   = 4'h0;
			drive_next = 1'b0;
		end else begin
			unique case (state_reg)
				scu_pkg::S_IDLE, scu_pkg::S_WAIT: begin
					// wait for a start
					drive_next = 1'b0;
				end
				scu_pkg::S_ADDR: begin
					if (byte_done) begin
						state_next = addr_match ? scu_pkg::S_ACK_A : scu_pkg::S_WAIT;
						drive_next = addr_match;
						cnt_next   = 4'h0;
					end
				end
				scu_pkg::S_ACK_A: begin
					if (scl_fall) begin
						state_next = rw_reg ? scu_pkg::S_RDATA : scu_pkg::S_PTR;
						drive_next = rw_reg & ~rd_val[7];
						tx_next    = rd_val;
						cnt_next   = 4'h0;
					end
				end
				scu_pkg::S_PTR: begin
					if (byte_done) begin
						state_next = scu_pkg::S_ACK_P;
						drive_next = 1'b1;
						cnt_next   = 4'h0;
					end
				end
				scu_pkg::S_ACK_P: begin
					// release after pointer ack
					if (scl_fall) begin
						state_next = scu_pkg::S_WDATA;
						drive_next = 1'b0;
						cnt_next   = 4'h0;
					end
				end
				scu_pkg::S_WDATA: begin
					if (byte_done) begin
						state_next = scu_pkg::S_ACK_W;
						drive_next = 1'b1;
						cnt_next   = 4'h0;
					end
				end
				scu_pkg::S_ACK_W: begin
					// one byte per write, then wait for a start
					if (scl_fall) begin
						state_next = scu_pkg::S_WAIT;
						drive_next = 1'b0;
					end
				end
				scu_pkg::S_RDATA: begin
					if (byte_done) begin
						state_next = scu_pkg::S_RACK;
						drive_next = 1'b0;
						cnt_next   = 4'h0;
					end else if (scl_fall) begin
						tx_next    = {tx_reg[6:0], 1'b0};
						drive_next = ~tx_reg[6];
					end
				end
				scu_pkg::S_RACK: begin
					if (scl_fall) begin
						state_next = scu_pkg::S_WAIT;
						drive_next = 1'b0;
					end
				end
				default: begin
					// illegal code recovers to idle
					state_next = scu_pkg::S_IDLE;
					drive_next = 1'b0;
				end
			endcase
		end
	end

	// engine flops
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= scu_pkg::S_IDLE;
			cnt_reg   <= 4'h0;
			drive_reg <= 1'b0;
			tx_reg    <= 8'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			drive_reg <= drive_next;
			tx_reg    <= tx_next;
		end
	end

	// bit capture, pointer and direction
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			shift_reg <= 8'h00;
			ptr_reg   <= 8'h00;
			rw_reg    <= 1'b0;
		end else begin
			if (scl_rise) begin
				shift_reg <= {shift_reg[6:0], sda_s};
			end
			// direction bit kept with the address
			if ((state_reg == scu_pkg::S_ADDR) && byte_done) begin
				rw_reg <= shift_reg[0];
			end
			if ((state_reg == scu_pkg::S_PTR) && byte_done) begin
				ptr_reg <= shift_reg;
			end
		end
	end

	// edge history and serial takeover
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			serial_reg   <= 1'b0;
		end else begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
			serial_reg   <= serial_reg | ack_addr;
		end
	end

	// open-drain pin and outputs
	assign sda_out        = 1'b0;
	assign sda_oe_n       = ~drive_reg;
	assign serial_mode    = serial_reg;
	assign phys_hs_modes  = phys[scu_pkg::IDX_HS];
	assign phys_aux_modes = phys[scu_pkg::IDX_AUX];
	assign phys_rx_set    = phys[scu_pkg::IDX_RX];
	assign phys_tx_set    = phys[scu_pkg::IDX_TX];

	// parallel tracking before takeover
	property p_par_track;
		@(posedge ref_clk) disable iff (!resetn)
		!serial_reg |=> (cfg_reg[0] == $past(par_word[0])) && (cfg_reg[3] == $past(par_word[3]));
	endproperty
	a_par_track: assert property (p_par_track) else $error("parallel not tracked");

	// takeover is permanent until reset
	property p_sticky;
		@(posedge ref_clk) disable iff (!resetn)
		serial_reg |=> serial_reg;
	endproperty
	a_sticky: assert property (p_sticky) else $error("serial mode dropped");

	// pins ignored in serial mode
	property p_ignore;
		@(posedge ref_clk) disable iff (!resetn)
		(serial_reg && !wr_stb) |=> $stable(cfg_reg[0]) && $stable(cfg_reg[3]);
	endproperty
	a_ignore: assert property (p_ignore) else $error("register moved without write");

	// matched address takes over and acks
	property p_ack_addr;
		@(posedge ref_clk) disable iff (!resetn)
		ack_addr && !start_det && !stop_det |=> serial_reg && drive_reg
			&& (state_reg == scu_pkg::S_ACK_A);
	endproperty
	a_ack_addr: assert property (p_ack_addr) else $error("no ack on match");

	// mismatch leaves the bus released
	property p_nack;
		@(posedge ref_clk) disable iff (!resetn)
		(state_reg == scu_pkg::S_ADDR) && byte_done && !addr_match
			&& !start_det && !stop_det |=> !drive_reg ##1 !drive_reg;
	endproperty
	a_nack: assert property (p_nack) else $error("ack on foreign address");

	// pointer latched from the received byte
	property p_ptr;
		@(posedge ref_clk) disable iff (!resetn)
		(state_reg == scu_pkg::S_PTR) && byte_done |=> ptr_reg == $past(shift_reg);
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer not latched");

	// written byte lands in the pointed register
	property p_store;
		@(posedge ref_clk) disable iff (!resetn)
		wr_stb && ptr_hit && serial_reg |=> cfg_reg[$past(ptr_idx)] == $past(shift_reg);
	endproperty
	a_store: assert property (p_store) else $error("write not stored");

	// read starts with the register msb
	property p_rd_msb;
		@(posedge ref_clk) disable iff (!resetn)
		(state_reg == scu_pkg::S_ACK_A) && scl_fall && rw_reg && !start_det && !stop_det
			|=> (drive_reg == !$past(rd_val[7])) && (state_reg == scu_pkg::S_RDATA);
	endproperty
	a_rd_msb: assert property (p_rd_msb) else $error("read msb wrong");

endmodule

/* logic/scu_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for pins from outside the clock domain
module scu_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_reg;	// first stage, read only by q

	// plain two-flop chain
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule

/* logic/scu_upd_delay.sv */
`timescale 1ns/1ps
// per-register update window between stored and physical value
module scu_upd_delay #(
	parameter int WIN = 200
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [7:0] cfg_in,
	input  wire logic       kick,
	output logic      [7:0] phys
);

	logic [15:0] cnt_reg;	// cycles left in the open window
	wire         idle = (cnt_reg == 16'h0);

	// physical value lags the register
	// apply at once when idle, again at window close
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= 16'h0;
			phys    <= 8'h00;
		end else if (idle) begin
			if (kick) begin
				phys    <= cfg_in;
				cnt_reg <= 16'(WIN);
			end
		end else begin
			cnt_reg <= cnt_reg - 16'h1;
			if (cnt_reg == 16'h1) begin
				phys <= cfg_in;
			end
		end
	end

	// idle kick loads value and opens a full window
	property p_open;
		@(posedge clk) disable iff (!resetn)
		(idle && kick) |=> (phys == $past(cfg_in)) && (cnt_reg == 16'(WIN));
	endproperty
	a_open: assert property (p_open) else $error("window open failed");

	// a kick inside the window does not restart it
	property p_norestart;
		@(posedge clk) disable iff (!resetn)
		(!idle && kick) |=> (cnt_reg == $past(cnt_reg) - 16'h1);
	endproperty
	a_norestart: assert property (p_norestart) else $error("window restarted");

	// physical value frozen while the window runs
	property p_hold;
		@(posedge clk) disable iff (!resetn)
		(cnt_reg > 16'h1) |=> $stable(phys);
	endproperty
	a_hold: assert property (p_hold) else $error("early physical update");

	// closing applies the newest value
	property p_close;
		@(posedge clk) disable iff (!resetn)
		(cnt_reg == 16'h1) |=> (phys == $past(cfg_in)) && idle;
	endproperty
	a_close: assert property (p_close) else $error("close missed value");

endmodule

/* sim/scu_i2c_master.sv */
`timescale 1ns/1ps
// bus master model, 80 ns bit time, lines pulled up
module scu_i2c_master (
	input  wire logic sda_out,
	input  wire logic sda_oe_n,
	output logic      scl,
	output logic      sda
);
	logic m_low; // master pulls data low

	// wired-and of both pullers over the pull-up
	assign sda = (m_low || (!sda_oe_n && !sda_out)) ? 1'h0 : 1'h1;

	// scl stands high between frames
	initial begin
		scl = 1'h1;
		m_low = 1'h0;
	end

	// one bit: set while scl low, sample mid high
	task automatic bit_x(input logic b, output logic r);
		#20 m_low = !b;
		#20 scl = 1'h1;
		#20 r = sda;
		#20 scl = 1'h0;
	endtask

	task automatic start();
		#20 m_low = 1'h0;
		#20 scl = 1'h1;
		#20 m_low = 1'h1;
		#20 scl = 1'h0;
	endtask

	task automatic stop();
		#20 m_low = 1'h1;
		#20 scl = 1'h1;
		#20 m_low = 1'h0;
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'h1, r);
		ack = !r;
	endtask

	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'h1, r);
			d[i] = r;
		end
		bit_x(!mack, r);
	endtask
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
// bench for the serial control and update logic
module tb_top;
	logic       ref_clk;         // 200 MHz clock
	logic       resetn;          // async reset
	logic       scl;             // bus clock
	logic       sda;             // resolved bus data
	logic       sda_out;         // device data pin
	logic       sda_oe_n;        // device pull enable
	logic [2:0] strap;           // address straps
	logic       par_out_en;      // parallel enable
	logic [1:0] par_sel;         // parallel select
	logic [1:0] par_pre;         // parallel pre-emphasis
	logic       par_oto;         // parallel termination
	logic       par_ocl;         // parallel current
	logic [7:0] phys_hs;         // applied words
	logic [7:0] phys_aux;
	logic [7:0] phys_rx;
	logic [7:0] phys_tx;
	logic       serial_mode;     // serial has taken over
	logic       ack;             // last ack seen
	logic [7:0] rd;              // last byte read
	logic [7:0] e_hs;            // held expectations
	logic [7:0] e_tx;
	int         n_errors;
	int         samples_checked;

	scu_serial_ctrl i_scu_serial_ctrl (
		.ref_clk(ref_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.slave_addr_strap_bit2(strap[2]), .slave_addr_strap_bit1(strap[1]),
		.slave_addr_strap_bit0(strap[0]), .par_out_en(par_out_en),
		.par_sel(par_sel), .par_pre(par_pre), .par_oto(par_oto), .par_ocl(par_ocl),
		.phys_hs_modes(phys_hs), .phys_aux_modes(phys_aux), .phys_rx_set(phys_rx),
		.phys_tx_set(phys_tx), .serial_mode(serial_mode)
	);

	scu_i2c_master i_scu_i2c_master (
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda)
	);

	// clock
	initial ref_clk = 1'h0;
	always #2.5 ref_clk = ~ref_clk;

	// expected parallel-derived words
	function automatic logic [7:0] exp_hs();
		return {1'h0, par_out_en, 4'h0, par_sel};
	endfunction
	function automatic logic [7:0] exp_tx();
		return {4'h0, par_pre, par_oto, par_ocl};
	endfunction

	// wait n edges, then settle
	task automatic wcyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// compare and count
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask

	// start plus address byte
	task automatic open(input logic rw, input logic [2:0] a);
		i_scu_i2c_master.start();
		i_scu_i2c_master.wbyte({scu_pkg::ADDR_PREFIX, a, rw}, ack);
	endtask

	// hs, aux and tx defaults follow the parallel pins, rx at its constant default
	task automatic t_defaults();
		chk("hs", exp_hs(), phys_hs);
		chk("aux", exp_hs(), phys_aux);
		chk("rx", scu_pkg::RX_SET_DEFAULT, phys_rx);
		chk("tx", exp_tx(), phys_tx);
		chk("mode", 8'h00, {7'h0, serial_mode});
		$display("test defaults done");
	endtask

	// parallel changes, separate windows, held until close
	task automatic t_parallel();
		wcyc(250);
		@(posedge ref_clk);
		par_sel <= 2'h2;
		par_pre <= 2'h1;
		wcyc(8);
		e_hs = exp_hs();
		e_tx = exp_tx();
		chk("hs now", e_hs, phys_hs);
		chk("tx now", e_tx, phys_tx);
		@(posedge ref_clk);
		par_sel <= 2'h3;
		par_pre <= 2'h3;
		wcyc(8);
		chk("hs held", e_hs, phys_hs);
		wcyc(130);
		chk("tx closed", exp_tx(), phys_tx);
		chk("hs open", e_hs, phys_hs);
		wcyc(100);
		chk("hs closed", exp_hs(), phys_hs);
		$display("test parallel done");
	endtask

	// wrong address is not acknowledged
	task automatic t_bad_addr();
		open(1'h0, strap ^ 3'h1);
		i_scu_i2c_master.stop();
		chk("bad ack", 8'h00, {7'h0, ack});
		chk("mode", 8'h00, {7'h0, serial_mode});
		$display("test bad address done");
	endtask

	// write, immediate apply, read back by repeated start
	task automatic t_write();
		wcyc(250);
		open(1'h0, strap);
		chk("addr ack", 8'h01, {7'h0, ack});
		i_scu_i2c_master.wbyte(scu_pkg::PTR_HS_MODES, ack);
		chk("ptr ack", 8'h01, {7'h0, ack});
		i_scu_i2c_master.wbyte(8'h4a, ack);
		chk("data ack", 8'h01, {7'h0, ack});
		chk("hs applied", 8'h4a, phys_hs);
		chk("mode", 8'h01, {7'h0, serial_mode});
		open(1'h1, strap);
		chk("rd ack", 8'h01, {7'h0, ack});
		i_scu_i2c_master.rbyte(1'h1, rd);
		i_scu_i2c_master.stop();
		chk("hs read", 8'h4a, rd);
		$display("test write done");
	endtask

	// parallel pins ignored in serial mode
	task automatic t_ignored();
		@(posedge ref_clk);
		par_sel <= 2'h1;
		par_out_en <= 1'h0;
		wcyc(250);
		chk("hs kept", 8'h4a, phys_hs);
		$display("test ignored done");
	endtask

	// read via pointer phase at several pointers
	task automatic t_read(input logic [7:0] ptr, input logic [7:0] exp);
		open(1'h0, strap);
		i_scu_i2c_master.wbyte(ptr, ack);
		open(1'h1, strap);
		chk("rd ack", 8'h01, {7'h0, ack});
		i_scu_i2c_master.rbyte(1'h1, rd);
		chk("read", exp, rd);
		open(1'h1, strap);
		i_scu_i2c_master.rbyte(1'h1, rd);
		i_scu_i2c_master.stop();
		chk("reread", exp, rd);
		$display("test read %h done", ptr);
	endtask

	// reset in mid-run returns to parallel defaults
	task automatic t_rereset();
		@(posedge ref_clk);
		resetn <= 1'h0;
		wcyc(3);
		chk("hs rst", 8'h00, phys_hs);
		@(posedge ref_clk);
		resetn <= 1'h1;
		wcyc(20);
		chk("hs dflt", exp_hs(), phys_hs);
		chk("mode", 8'h00, {7'h0, serial_mode});
		$display("test reset again done");
	endtask

	// verdict
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		n_errors = 0;
		samples_checked = 0;
		resetn = 1'h0;
		strap = 3'h5;
		par_out_en = 1'h1;
		par_sel = 2'h1;
		par_pre = 2'h2;
		par_oto = 1'h1;
		par_ocl = 1'h0;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'h1;
		wcyc(20);
		t_defaults();
		t_parallel();
		t_bad_addr();
		t_write();
		t_ignored();
		t_read(scu_pkg::PTR_RX_SET, scu_pkg::RX_SET_DEFAULT);
		t_read(8'h05, scu_pkg::UNMAPPED_READ);
		// aux kept the parallel word seen at takeover: en 1, sel 3
		t_read(scu_pkg::PTR_AUX_MODES, 8'h43);
		t_read(scu_pkg::PTR_TX_SET, exp_tx());
		t_rereset();
		end_of_test();
	end

	// watchdog against a hung bus
	initial begin
		repeat (30000) @(posedge ref_clk);
		n_errors++;
		end_of_test();
	end
endmodule
